// ### design/hcp_map.vh
// Register offsets, field layout, characters and limits for the command parser
`ifndef HCP_MAP_VH
`define HCP_MAP_VH
`define HCP_A_CTRL 8'h00
`define HCP_A_STAT 8'h04
`define HCP_A_RX_PASSTHROUGH_ENABLE 8'h08
`define HCP_A_BRK 8'h0C
`define HCP_A_PEND 8'h10
`define HCP_A_BIDX 8'h14
`define HCP_A_BDAT 8'h18
`define HCP_A_MNEM 8'h1C
`define HCP_A_INFO 8'h20
`define HCP_A_P0 8'h24
`define HCP_A_P1 8'h28
`define HCP_A_PORT 8'h40
`define HCP_NPORT 13
`define HCP_CTL_RMC 0
`define HCP_CTL_RMD 1
`define HCP_CTL_TOKW 2
`define HCP_ST_CME 5
`define HCP_ST_BUS 0
`define HCP_ST_IDLE 1
`define HCP_BIT_MON 12
`define HCP_BIT_HOST 13
`define HCP_IDX_HOST 12
`define HCP_BAUD_9600 4'h4
`define HCP_DIP_LIMIT 4'h8
`define HCP_CFG_DEF 8'h44
`define HCP_CFG_WORD8 4'h4
`define HCP_BUF_MAX 8'hFF
`define HCP_MNEM_LEN 3'h4
`define HCP_CH_CR 8'h0D
`define HCP_CH_LF 8'h0A
`define HCP_CH_TAB 8'h09
`define HCP_CH_SP 8'h20
`define HCP_CH_DQ 8'h22
`define HCP_CH_HASH 8'h23
`define HCP_CH_SQ 8'h27
`define HCP_CH_STAR 8'h2A
`define HCP_CH_COMMA 8'h2C
`define HCP_CH_0 8'h30
`define HCP_CH_1 8'h31
`define HCP_CH_9 8'h39
`define HCP_CH_SEMI 8'h3B
`define HCP_CH_QM 8'h3F
`define HCP_CH_A 8'h41
`define HCP_CH_F 8'h46
`define HCP_CH_H 8'h48
`define HCP_CH_X 8'h58
`define HCP_CH_Z 8'h5A
`define HCP_CH_LA 8'h61
`define HCP_CH_LZ 8'h7A
`define HCP_CASE 8'h20
`define HCP_HEX_OFS 8'h37
`define HCP_B_DEC 2'h0
`define HCP_B_OCT 2'h1
`define HCP_B_HEX 2'h2
`define HCP_B_TOK 2'h3
`endif

// ### design/hcp_parser.v
// Host command parser with port settings and APB register file
`timescale 1ns/1ps
`include "hcp_map.vh"
// Operation
// - Ports 1 to B reset 9600 8N1
// - Monitor copies host traffic unless remapped
// - Host port baud from switches, else 9600
// - Monitor and host port settings always writable
// - Unremapped monitor/host bits stored but inert
// - Mnemonic four characters, case-insensitive
// - Asterisk plus three letters, or four letters
// - Question mark after mnemonic means query, except when the question mark itself carries bus EOI
// - 255-byte command and block limits
// - Serial CR or LF ends outside blocks
// - Bus ends on LF or EOI
// - Command issued only after its terminator
// - Semicolon command sequences rejected
// - Port as decimal or single hex letter
// - Port parameter selects bit two-to-p, E allowed
// - Integers decimal, octal or 0x hex
// - Token as keyword or decimal code
// - Token reply format selectable
// - Quoted strings, doubled quote is literal
// - Hash-H hex pairs, whitespace ignored
// - Definite-length block by digit count
// - Bus-only indefinite block until LF with EOI
// - Syntax errors set command error flag
// - Clear or break flushes, parser idles
module hcp_parser (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // Host byte stream
  input wire in_valid,
  input wire [7:0] in_data,
  input wire in_eoi,
  input wire host_is_bus,
  input wire dev_clear,
  input wire serial_break,
  input wire [3:0] dip_baud,
  input wire [14:0] pend_set,
  // Parsed command
  output reg cmd_valid_q,
  output reg cmd_query_q,
  output reg cmd_common_q,
  output reg [31:0] cmd_mnem_q,
  output reg [1:0] cmd_nparam_q,
  output reg [31:0] cmd_p0_q,
  output reg [31:0] cmd_p1_q,
  output reg [14:0] cmd_pmask_q,
  output reg [7:0] cmd_blen_q,
  // Port roles and settings
  output reg host_flush_q,
  output reg monitor_copy_q,
  output reg host_port_active_q,
  output reg token_keyword_q,
  output reg [14:0] rx_passthrough_enable_eff_q,
  output reg [14:0] brk_eff_q,
  output reg [103:0] port_cfg_q
);
  localparam [9:0] S_MN = 10'h001;
  localparam [9:0] S_PAR = 10'h002;
  localparam [9:0] S_STR = 10'h004;
  localparam [9:0] S_QEND = 10'h008;
  localparam [9:0] S_HASH = 10'h010;
  localparam [9:0] S_HEX = 10'h020;
  localparam [9:0] S_DLEN = 10'h040;
  localparam [9:0] S_RAW = 10'h080;
  localparam [9:0] S_INDEF = 10'h100;
  localparam [9:0] S_SKIP = 10'h200;

  reg [9:0] st_q;
  reg [31:0] mn_q;
  reg [2:0] mlen_q;
  reg query_q;
  reg [7:0] clen_q;
  reg [1:0] base_q;
  reg [31:0] acc_q;
  reg [2:0] tl_q;
  reg pstart_q;
  reg [1:0] pc_q;
  reg [31:0] p0_q;
  reg [31:0] p1_q;
  reg [7:0] delim_q;
  reg [3:0] ndig_q;
  reg [9:0] bcnt_q;
  reg [7:0] blen_q;
  reg nib_q;
  reg [3:0] nibh_q;
  reg [7:0] blk_mem [0:254];
  reg [7:0] bidx_q;
  reg remap_monitor_port_cmd_q;
  reg remap_host_port_cmd_q;
  reg token_format_cmd_q;
  reg command_error_flag_q;
  reg [14:0] rx_passthrough_enable_q;
  reg [14:0] break_enable_reg_q;
  reg [14:0] port_data_pending_q;
  reg dip_done_q;
  reg host_bus_q;
  reg cme_set;

  wire [7:0] b = in_data;
  wire lower = (b >= `HCP_CH_LA) && (b <= `HCP_CH_LZ);
  wire [7:0] u = lower ? (b & ~`HCP_CASE) : b;
  wire is_let = (u >= `HCP_CH_A) && (u <= `HCP_CH_Z);
  wire is_dig = (b >= `HCP_CH_0) && (b <= `HCP_CH_9);
  wire is_hexl = (u >= `HCP_CH_A) && (u <= `HCP_CH_F);
  wire [7:0] dval = b - `HCP_CH_0;
  wire [7:0] hval = is_dig ? dval : (u - `HCP_HEX_OFS);
  wire is_ws = (b == `HCP_CH_SP) || (b == `HCP_CH_TAB);
  wire is_lf = (b == `HCP_CH_LF);
  wire term = host_bus_q ? (is_lf || in_eoi) : (is_lf || b == `HCP_CH_CR);
  wire lf_eoi = is_lf && in_eoi;
  // Parameter-state bytes, and the byte that follows a closing quote or a hex block, run through the parameter logic
  wire pb = (st_q == S_PAR) || (st_q == S_QEND && b != delim_q) ||
    (st_q == S_HEX && !(is_dig || is_hexl) && !is_ws);
  // Lone hex letter stands for a port number
  wire [7:0] tokhex = acc_q[7:0] - `HCP_HEX_OFS;
  wire [31:0] val_w = (base_q == `HCP_B_TOK && tl_q == 3'h1 &&
    acc_q[7:0] >= `HCP_CH_A && acc_q[7:0] <= `HCP_CH_F) ? {24'h0, tokhex} : acc_q;
  wire [31:0] f0_w = (pstart_q && pc_q == 2'h0) ? val_w : p0_q;
  wire [31:0] f1_w = (pstart_q && pc_q == 2'h1) ? val_w : p1_q;
  wire [31:0] dec10 = {acc_q[28:0], 3'h0} + {acc_q[30:0], 1'h0};
  wire [9:0] bc10 = {bcnt_q[6:0], 3'h0} + {bcnt_q[8:0], 1'h0} + {2'h0, dval};

  task t_clr;
    begin
      st_q <= S_MN;
      mlen_q <= 3'h0;
      query_q <= 1'b0;
      clen_q <= 8'h00;
      pstart_q <= 1'b0;
      pc_q <= 2'h0;
      p0_q <= 32'h0;
      p1_q <= 32'h0;
      blen_q <= 8'h00;
      nib_q <= 1'b0;
    end
  endtask

  task t_err;
    begin
      cme_set <= 1'b1;
      if (term) t_clr;
      else st_q <= S_SKIP;
    end
  endtask

  task t_put;
    begin
      if (blen_q == `HCP_BUF_MAX) t_err;
      else begin
        blk_mem[blen_q] <= b;
        blen_q <= blen_q + 8'h01;
      end
    end
  endtask

  task t_close;
    begin
      if (pstart_q && pc_q == 2'h0) p0_q <= val_w;
      if (pstart_q && pc_q == 2'h1) p1_q <= val_w;
      if (pstart_q && pc_q != 2'h3) pc_q <= pc_q + 2'h1;
      pstart_q <= 1'b0;
    end
  endtask

  task t_done;
    begin
      cmd_valid_q <= 1'b1;
      cmd_query_q <= query_q;
      cmd_common_q <= (mn_q[31:24] == `HCP_CH_STAR);
      cmd_mnem_q <= mn_q;
      cmd_nparam_q <= pc_q + {1'b0, pstart_q};
      cmd_p0_q <= f0_w;
      cmd_p1_q <= f1_w;
      cmd_pmask_q <= (f0_w < 32'd15) ? (15'h1 << f0_w[3:0]) : 15'h0;
      cmd_blen_q <= blen_q;
      t_clr;
    end
  endtask

  // Parser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_MN;
      mn_q <= 32'h0;
      mlen_q <= 3'h0;
      query_q <= 1'b0;
      clen_q <= 8'h00;
      base_q <= `HCP_B_DEC;
      acc_q <= 32'h0;
      tl_q <= 3'h0;
      pstart_q <= 1'b0;
      pc_q <= 2'h0;
      p0_q <= 32'h0;
      p1_q <= 32'h0;
      delim_q <= 8'h00;
      ndig_q <= 4'h0;
      bcnt_q <= 10'h000;
      blen_q <= 8'h00;
      nib_q <= 1'b0;
      nibh_q <= 4'h0;
      cme_set <= 1'b0;
      host_flush_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_query_q <= 1'b0;
      cmd_common_q <= 1'b0;
      cmd_mnem_q <= 32'h0;
      cmd_nparam_q <= 2'h0;
      cmd_p0_q <= 32'h0;
      cmd_p1_q <= 32'h0;
      cmd_pmask_q <= 15'h0;
      cmd_blen_q <= 8'h00;
    end else begin
      cmd_valid_q <= 1'b0;
      cme_set <= 1'b0;
      host_flush_q <= 1'b0;
      if (dev_clear || serial_break) begin
        host_flush_q <= 1'b1;
        t_clr;
      end else if (in_valid) begin
        if (st_q == S_MN || pb) clen_q <= clen_q + 8'h01;
        if ((st_q == S_MN || pb) && clen_q == `HCP_BUF_MAX && !term) t_err;
        else if (pb) begin
          if (st_q == S_HEX && nib_q) t_err;
          else if (term) begin
            if (host_bus_q && !is_lf && b != `HCP_CH_CR) t_err;
            else t_done;
          end else if (b == `HCP_CH_SEMI) t_err;
          else if (is_ws) begin
            st_q <= S_PAR;
          end else if (b == `HCP_CH_COMMA) begin
            st_q <= S_PAR;
            t_close;
          end else if (pstart_q && st_q != S_PAR) t_err;
          else if (b == `HCP_CH_DQ || b == `HCP_CH_SQ) begin
            if (pstart_q) t_err;
            else begin
              delim_q <= b;
              pstart_q <= 1'b1;
              st_q <= S_STR;
            end
          end else if (b == `HCP_CH_HASH) begin
            if (pstart_q) t_err;
            else begin
              pstart_q <= 1'b1;
              st_q <= S_HASH;
            end
          end else if (!pstart_q && (is_dig || is_let)) begin
            pstart_q <= 1'b1;
            st_q <= S_PAR;
            tl_q <= 3'h1;
            acc_q <= is_dig ? {24'h0, dval} : {24'h0, u};
            if (is_let) base_q <= `HCP_B_TOK;
            else if (b == `HCP_CH_0) base_q <= `HCP_B_OCT;
            else base_q <= `HCP_B_DEC;
          end else begin
            if (tl_q != 3'h7) tl_q <= tl_q + 3'h1;
            if (base_q == `HCP_B_OCT && u == `HCP_CH_X && tl_q == 3'h1)
              base_q <= `HCP_B_HEX;
            else if (base_q == `HCP_B_DEC && is_dig) acc_q <= dec10 + {24'h0, dval};
            else if (base_q == `HCP_B_OCT && is_dig && dval < 8'h08)
              acc_q <= {acc_q[28:0], dval[2:0]};
            else if (base_q == `HCP_B_HEX && (is_dig || is_hexl))
              acc_q <= {acc_q[27:0], hval[3:0]};
            else if (base_q == `HCP_B_TOK && (is_let || is_dig))
              acc_q <= {acc_q[23:0], u};
            else t_err;
          end
        end else begin
          case (st_q)
            S_MN: begin
              if (term && mlen_q == 3'h0) t_clr;
              else if (mlen_q == `HCP_MNEM_LEN && (term || is_ws || b == `HCP_CH_QM)) begin
                if (term) t_done;
                else begin
                  query_q <= (b == `HCP_CH_QM);
                  st_q <= S_PAR;
                end
              end else if (mlen_q != `HCP_MNEM_LEN &&
                (is_let || (mlen_q == 3'h0 && b == `HCP_CH_STAR))) begin
                mn_q <= {mn_q[23:0], u};
                mlen_q <= mlen_q + 3'h1;
                // Bus EOI may ride on the last mnemonic letter
                if (term && mlen_q == `HCP_MNEM_LEN - 3'h1) begin
                  t_done;
                  cmd_mnem_q <= {mn_q[23:0], u};
                  cmd_common_q <= (mn_q[23:16] == `HCP_CH_STAR);
                end else if (term) t_err;
              end else t_err;
            end
            S_STR: begin
              if (b == delim_q) st_q <= S_QEND;
              else t_put;
            end
            S_QEND: begin
              st_q <= S_STR;
              t_put;
            end
            S_HASH: begin
              if (u == `HCP_CH_H) begin
                nib_q <= 1'b0;
                st_q <= S_HEX;
              end else if (b == `HCP_CH_0 && host_bus_q) st_q <= S_INDEF;
              else if (is_dig && b != `HCP_CH_0) begin
                ndig_q <= dval[3:0];
                bcnt_q <= 10'h000;
                st_q <= S_DLEN;
              end else t_err;
            end
            S_HEX: begin
              if (!is_ws) begin
                nib_q <= ~nib_q;
                nibh_q <= hval[3:0];
                if (nib_q) begin
                  if (blen_q == `HCP_BUF_MAX) t_err;
                  else begin
                    blk_mem[blen_q] <= {nibh_q, hval[3:0]};
                    blen_q <= blen_q + 8'h01;
                  end
                end
              end
            end
            S_DLEN: begin
              if (!is_dig || bc10 > {2'h0, `HCP_BUF_MAX}) t_err;
              else begin
                bcnt_q <= bc10;
                ndig_q <= ndig_q - 4'h1;
                if (ndig_q == 4'h1) st_q <= (bc10 == 10'h000) ? S_PAR : S_RAW;
              end
            end
            S_RAW: begin
              t_put;
              bcnt_q <= bcnt_q - 10'h001;
              if (bcnt_q == 10'h001) st_q <= S_PAR;
            end
            S_INDEF: begin
              if (lf_eoi) t_done;
              else t_put;
            end
            S_SKIP: begin
              if (term) t_clr;
            end
            default: t_clr;
          endcase
        end
      end
    end
  end

  // APB slave, one wait state per access
  wire acc_w = psel && penable && pready_q;
  wire wr_w = acc_w && pwrite;
  wire [14:0] pmask_w = {1'b1, remap_host_port_cmd_q, remap_monitor_port_cmd_q, 12'hFFF};
  reg [31:0] rd_w;
  reg hit_w;
  integer k;

  always @* begin
    hit_w = 1'b1;
    rd_w = 32'h0;
    case (paddr)
      `HCP_A_CTRL: rd_w = {29'h0, token_format_cmd_q, remap_host_port_cmd_q,
        remap_monitor_port_cmd_q};
      `HCP_A_STAT: rd_w = {26'h0, command_error_flag_q, 3'h0, (st_q == S_MN), host_bus_q};
      `HCP_A_RX_PASSTHROUGH_ENABLE: rd_w = {17'h0, rx_passthrough_enable_q};
      `HCP_A_BRK: rd_w = {17'h0, break_enable_reg_q};
      `HCP_A_PEND: rd_w = {17'h0, port_data_pending_q};
      `HCP_A_BIDX: rd_w = {24'h0, bidx_q};
      `HCP_A_BDAT: rd_w = (bidx_q == `HCP_BUF_MAX) ? 32'h0 : {24'h0, blk_mem[bidx_q]};
      `HCP_A_MNEM: rd_w = cmd_mnem_q;
      `HCP_A_INFO: rd_w = {20'h0, cmd_blen_q, cmd_nparam_q, cmd_common_q, cmd_query_q};
      `HCP_A_P0: rd_w = cmd_p0_q;
      `HCP_A_P1: rd_w = cmd_p1_q;
      default: hit_w = 1'b0;
    endcase
    for (k = 0; k < `HCP_NPORT; k = k + 1) begin
      if (paddr == `HCP_A_PORT + k[5:0] * 8'h04) begin
        hit_w = 1'b1;
        rd_w = {24'h0, port_cfg_q[k*8 +: 8]};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      remap_monitor_port_cmd_q <= 1'b0;
      remap_host_port_cmd_q <= 1'b0;
      token_format_cmd_q <= 1'b0;
      command_error_flag_q <= 1'b0;
      rx_passthrough_enable_q <= 15'h0;
      break_enable_reg_q <= 15'h0;
      port_data_pending_q <= 15'h0;
      bidx_q <= 8'h00;
      dip_done_q <= 1'b0;
      host_bus_q <= 1'b0;
      monitor_copy_q <= 1'b1;
      host_port_active_q <= 1'b0;
      token_keyword_q <= 1'b0;
      rx_passthrough_enable_eff_q <= 15'h0;
      brk_eff_q <= 15'h0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit_w;
      if (psel && penable && !pready_q && !pwrite) prdata_q <= rd_w;
      dip_done_q <= 1'b1;
      host_bus_q <= host_is_bus;
      if (wr_w && paddr == `HCP_A_CTRL) begin
        remap_monitor_port_cmd_q <= pwdata[`HCP_CTL_RMC];
        remap_host_port_cmd_q <= pwdata[`HCP_CTL_RMD];
        token_format_cmd_q <= pwdata[`HCP_CTL_TOKW];
      end
      // Hardware set beats a same-cycle software clear
      command_error_flag_q <= cme_set || (command_error_flag_q &&
        !(wr_w && paddr == `HCP_A_STAT && pwdata[`HCP_ST_CME]));
      port_data_pending_q <= pend_set | (port_data_pending_q &
        ~((wr_w && paddr == `HCP_A_PEND) ? pwdata[14:0] : 15'h0));
      if (wr_w && paddr == `HCP_A_RX_PASSTHROUGH_ENABLE) rx_passthrough_enable_q <= pwdata[14:0];
      if (wr_w && paddr == `HCP_A_BRK) break_enable_reg_q <= pwdata[14:0];
      if (wr_w && paddr == `HCP_A_BIDX) bidx_q <= pwdata[7:0];
      monitor_copy_q <= !remap_monitor_port_cmd_q;
      host_port_active_q <= !host_bus_q || remap_host_port_cmd_q;
      token_keyword_q <= token_format_cmd_q;
      rx_passthrough_enable_eff_q <= rx_passthrough_enable_q & pmask_w;
      brk_eff_q <= break_enable_reg_q & pmask_w;
    end
  end

  // Per-port serial settings
  genvar g;
  generate
    for (g = 0; g < `HCP_NPORT; g = g + 1) begin : g_port
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_cfg_q[g*8 +: 8] <= `HCP_CFG_DEF;
        end else if (g == `HCP_IDX_HOST && !dip_done_q) begin
          // Switch level caught on the first edge after release
          port_cfg_q[g*8 +: 8] <= {`HCP_CFG_WORD8,
            (dip_baud < `HCP_DIP_LIMIT) ? dip_baud : `HCP_BAUD_9600};
        end else if (wr_w && paddr == `HCP_A_PORT + g * 4) begin
          port_cfg_q[g*8 +: 8] <= pwdata[7:0];
        end
      end
    end
  endgenerate
endmodule

// ### verif/hcp_host.sv
// Host computer model sending command bytes to the parser
`timescale 1ns/1ps
module hcp_host (
  // Clock
  input wire pclk,
  // Byte stream
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_eoi
);
  initial begin
    in_valid = 1'h0;
    in_data = 8'h00;
    in_eoi = 1'h0;
  end
  // One command per message, bytes back to back; EOI only on the last byte
  task automatic send(input string s, input logic eoi);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge pclk);
      in_valid <= 1'h1;
      in_data <= s[i];
      in_eoi <= eoi && (i == s.len() - 1);
    end
    @(posedge pclk);
    in_valid <= 1'h0;
    // Idle data shows no stale byte
    in_data <= ~s[s.len() - 1];
    in_eoi <= 1'h0;
  endtask
endmodule

// ### verif/hcp_parser_properties.sv
// Port checker for the host command parser
`timescale 1ns/1ps
`include "hcp_map.vh"
module hcp_parser_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Host side
  input wire in_valid,
  input wire [7:0] in_data,
  input wire in_eoi,
  input wire host_is_bus,
  input wire dev_clear,
  input wire serial_break,
  input wire [3:0] dip_baud,
  // Outputs
  input wire cmd_valid_q,
  input wire cmd_common_q,
  input wire [31:0] cmd_mnem_q,
  input wire [31:0] cmd_p0_q,
  input wire [14:0] cmd_pmask_q,
  input wire host_flush_q,
  input wire monitor_copy_q,
  input wire host_port_active_q,
  input wire [14:0] rx_passthrough_enable_eff_q,
  input wire [14:0] brk_eff_q,
  input wire [103:0] port_cfg_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  function automatic logic up(input logic [7:0] c);
    return c >= `HCP_CH_A && c <= `HCP_CH_Z;
  endfunction
  sequence s_term;
    $past(in_valid) && ($past(in_data) == `HCP_CH_LF || $past(in_data) == `HCP_CH_CR
      || $past(in_eoi));
  endsequence
  sequence s_serial;
    !host_is_bus [*3];
  endsequence
  property p_term; cmd_valid_q |-> s_term; endproperty
  property p_flush; dev_clear || serial_break |=> host_flush_q && !cmd_valid_q; endproperty
  property p_mon; monitor_copy_q |-> !rx_passthrough_enable_eff_q[12] && !brk_eff_q[12]; endproperty
  property p_active; s_serial |-> host_port_active_q; endproperty
  property p_cfg_rst; !$past(presetn) |-> port_cfg_q[95:0] == {12{`HCP_CFG_DEF}}; endproperty
  property p_cfg_dip;
    !$past(presetn, 2) && $past(presetn) |-> port_cfg_q[103:96] == {`HCP_CFG_WORD8,
      ($past(dip_baud) < `HCP_DIP_LIMIT) ? $past(dip_baud) : `HCP_BAUD_9600};
  endproperty
  property p_common; cmd_valid_q && cmd_common_q |-> cmd_mnem_q[31:24] == `HCP_CH_STAR;
  endproperty
  property p_upper;
    cmd_valid_q && !cmd_common_q |-> up(cmd_mnem_q[31:24]) && up(cmd_mnem_q[23:16])
      && up(cmd_mnem_q[15:8]) && up(cmd_mnem_q[7:0]);
  endproperty
  property p_mask;
    cmd_valid_q |-> cmd_pmask_q == ((cmd_p0_q < 15) ? (15'h0001 << cmd_p0_q) : 15'h0000);
  endproperty
  a_term: assert property (p_term) else $error("command without terminator");
  a_flush: assert property (p_flush) else $error("clear did not flush");
  a_mon: assert property (p_mon) else $error("monitor bit active");
  a_active: assert property (p_active) else $error("host port inactive");
  a_cfg_rst: assert property (p_cfg_rst) else $error("port reset setting");
  a_cfg_dip: assert property (p_cfg_dip) else $error("host port baud");
  a_common: assert property (p_common) else $error("common without star");
  a_upper: assert property (p_upper) else $error("mnemonic not letters");
  a_mask: assert property (p_mask) else $error("port mask wrong");
endmodule
bind hcp_parser hcp_parser_props u_props (.pclk(pclk), .presetn(presetn),
  .in_valid(in_valid), .in_data(in_data), .in_eoi(in_eoi), .host_is_bus(host_is_bus),
  .dev_clear(dev_clear), .serial_break(serial_break), .dip_baud(dip_baud),
  .cmd_valid_q(cmd_valid_q), .cmd_common_q(cmd_common_q), .cmd_mnem_q(cmd_mnem_q),
  .cmd_p0_q(cmd_p0_q), .cmd_pmask_q(cmd_pmask_q), .host_flush_q(host_flush_q),
  .monitor_copy_q(monitor_copy_q), .host_port_active_q(host_port_active_q),
  .rx_passthrough_enable_eff_q(rx_passthrough_enable_eff_q), .brk_eff_q(brk_eff_q), .port_cfg_q(port_cfg_q));

// ### verif/hcp_parser_tb.sv
// Self-checking bench for the host command parser
`timescale 1ns/1ps
`include "hcp_map.vh"
module hcp_parser_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
  logic host_is_bus = 1'h0, dev_clear = 1'h0, serial_break = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] dip_baud = 4'h3;
  logic [14:0] pend_set = 15'h0;
  wire in_valid, in_eoi, pready_q, pslverr_q, cmd_valid_q, cmd_query_q, cmd_common_q;
  wire host_flush_q, monitor_copy_q, host_port_active_q, token_keyword_q;
  wire [7:0] in_data, cmd_blen_q;
  wire [31:0] prdata_q, cmd_mnem_q, cmd_p0_q, cmd_p1_q;
  wire [1:0] cmd_nparam_q;
  wire [14:0] cmd_pmask_q, rx_passthrough_enable_eff_q, brk_eff_q;
  wire [103:0] port_cfg_q;
  int err_count = 0, comparisons = 0, vcnt = 0, cyc = 0;
  initial forever #12.5 pclk = ~pclk;
  hcp_host u_host (.pclk(pclk), .in_valid(in_valid), .in_data(in_data), .in_eoi(in_eoi));
  hcp_parser u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .in_valid(in_valid), .in_data(in_data),
    .in_eoi(in_eoi), .host_is_bus(host_is_bus), .dev_clear(dev_clear),
    .serial_break(serial_break), .dip_baud(dip_baud), .pend_set(pend_set),
    .cmd_valid_q(cmd_valid_q), .cmd_query_q(cmd_query_q), .cmd_common_q(cmd_common_q),
    .cmd_mnem_q(cmd_mnem_q), .cmd_nparam_q(cmd_nparam_q), .cmd_p0_q(cmd_p0_q),
    .cmd_p1_q(cmd_p1_q), .cmd_pmask_q(cmd_pmask_q), .cmd_blen_q(cmd_blen_q),
    .host_flush_q(host_flush_q), .monitor_copy_q(monitor_copy_q),
    .host_port_active_q(host_port_active_q), .token_keyword_q(token_keyword_q),
    .rx_passthrough_enable_eff_q(rx_passthrough_enable_eff_q), .brk_eff_q(brk_eff_q), .port_cfg_q(port_cfg_q));
  always @(posedge pclk) if (cmd_valid_q === 1'h1) vcnt <= vcnt + 1;
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, well above the whole sequence
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // No assumed latency; only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'h1);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmd(input string s, input logic eoi, input int ok);
    int v;
    v = vcnt;
    u_host.send(s, eoi);
    repeat (3) @(posedge pclk);
    #1;
    chk("cmd count", ok, vcnt - v);
  endtask
  task automatic t_reset(input logic [3:0] dip, input logic [7:0] pd);
    @(posedge pclk);
    dip_baud <= dip;
    presetn <= 1'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    #1;
    for (int k = 0; k < 12; k++) chk("cfg", 8'h44, port_cfg_q[8*k +: 8]);
    chk("cfg d", pd, port_cfg_q[103:96]);
    chk("mon", 1, monitor_copy_q);
    chk("active", 1, host_port_active_q);
    apb(1'h0, `HCP_A_PORT, 32'h0);
    chk("port1", 32'h44, rd);
    apb(1'h0, 8'h3C, 32'h0);
    chk("slverr", 1, er);
  endtask
  task automatic t_query;
    cmd("*idn?", 1'h0, 0);
    cmd("\n", 1'h0, 1);
    chk("mnem", 32'h2A49444E, cmd_mnem_q);
    chk("query", 1, cmd_query_q);
    chk("common", 1, cmd_common_q);
  endtask
  task automatic t_params;
    string c[4] = '{"SBIT 3,0x1A\r", "sbit e,032\n", "WAIT 26\n", "TERM CRLF\n"};
    logic [31:0] p0[4] = '{32'h3, 32'hE, 32'h1A, 32'h43524C46};
    logic [14:0] m[4] = '{15'h0008, 15'h4000, 15'h0000, 15'h0000};
    for (int i = 0; i < 4; i++) begin
      cmd(c[i], 1'h0, 1);
      chk("p0", p0[i], cmd_p0_q);
      chk("pmask", m[i], cmd_pmask_q);
      chk("query", 0, cmd_query_q);
      chk("nparam", (i < 2) ? 2 : 1, cmd_nparam_q);
      if (i < 2) chk("p1", 32'h1A, cmd_p1_q);
    end
  endtask
  task automatic t_blocks;
    string c[5] = '{"SEND 4,\"a\nb\"\n", "SEND 4,'a''b'\r", "SEND 4,#H41 4a\n",
      "SEND 4,#13x\ry\n", "SEND 4,\"\"\"\"\n"};
    logic [7:0] n[5] = '{8'h03, 8'h03, 8'h02, 8'h03, 8'h01};
    for (int i = 0; i < 5; i++) begin
      cmd(c[i], 1'h0, 1);
      chk("blen", n[i], cmd_blen_q);
      if (i == 2) begin
        apb(1'h1, `HCP_A_BIDX, 32'h1);
        apb(1'h0, `HCP_A_BDAT, 32'h0);
        chk("blk byte", 32'h4A, rd);
      end
    end
  endtask
  task automatic t_errors;
    string s;
    cmd("ABCD 1;*CLS\n", 1'h0, 0);
    apb(1'h0, `HCP_A_STAT, 32'h0);
    chk("cmd error", 1, rd[`HCP_ST_CME]);
    apb(1'h1, `HCP_A_STAT, 32'h20);
    cmd("ABC 1\n", 1'h0, 0);
    cmd("SEND 4,#H414\r", 1'h0, 0);
    cmd("SEND 4,#0ab\n", 1'h0, 0);
    cmd("*RST\n", 1'h0, 1);
    s = "*RST";
    repeat (251) s = {s, " "};
    cmd({s, "\n"}, 1'h0, 1);
    cmd({s, " \n"}, 1'h0, 0);
    cmd("*RST\n", 1'h0, 1);
  endtask
  task automatic t_clear;
    for (int k = 0; k < 2; k++) begin
      u_host.send("*ID", 1'h0);
      if (k == 0) dev_clear <= 1'h1;
      else serial_break <= 1'h1;
      @(posedge pclk);
      dev_clear <= 1'h0;
      serial_break <= 1'h0;
      cmd("*CLS\n", 1'h0, 1);
      chk("mnem", 32'h2A434C53, cmd_mnem_q);
    end
  endtask
  task automatic t_remap;
    apb(1'h1, `HCP_A_RX_PASSTHROUGH_ENABLE, 32'h1000);
    apb(1'h1, `HCP_A_BRK, 32'h1008);
    pend_set <= 15'h1000;
    @(posedge pclk);
    pend_set <= 15'h0;
    apb(1'h0, `HCP_A_PEND, 32'h0);
    chk("pend", 32'h1000, rd);
    apb(1'h0, `HCP_A_RX_PASSTHROUGH_ENABLE, 32'h0);
    chk("rx_passthrough_enable rd", 32'h1000, rd);
    chk("rx_passthrough_enable eff", 0, rx_passthrough_enable_eff_q);
    chk("brk eff", 15'h0008, brk_eff_q);
    host_is_bus <= 1'h1;
    apb(1'h1, `HCP_A_CTRL, 32'h5);
    repeat (2) @(posedge pclk);
    #1;
    chk("rx_passthrough_enable eff", 15'h1000, rx_passthrough_enable_eff_q);
    chk("mon", 0, monitor_copy_q);
    chk("tok fmt", 1, token_keyword_q);
    chk("active", 0, host_port_active_q);
    apb(1'h1, `HCP_A_CTRL, 32'h2);
    apb(1'h1, `HCP_A_PORT + 8'h2C, 32'h41);
    repeat (2) @(posedge pclk);
    #1;
    chk("active", 1, host_port_active_q);
    chk("cfg c", 8'h41, port_cfg_q[95:88]);
    apb(1'h1, `HCP_A_CTRL, 32'h0);
  endtask
  task automatic t_bus;
    @(posedge pclk);
    host_is_bus <= 1'h1;
    cmd("*CLS", 1'h1, 1);
    cmd("*CLS\n", 1'h1, 1);
    cmd("*CLS\n", 1'h0, 1);
    cmd("SEND 4,#0a\nb\n", 1'h1, 1);
    chk("blen", 3, cmd_blen_q);
    @(posedge pclk);
    host_is_bus <= 1'h0;
  endtask
  initial begin
    t_reset(4'h3, 8'h43);
    t_reset(4'h9, 8'h44);
    t_query;
    t_params;
    t_blocks;
    t_errors;
    t_clear;
    t_remap;
    t_bus;
    print_verdict();
  end
endmodule
